// ### rtl/phy_vendor_pkg.sv
// Constants shared by the vendor management register block and its leaves.
// Assumes a 16-bit management data word and 5-bit register addresses.
package phy_vendor_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned ADDR_W   = 5;
  localparam int unsigned NUM_EVT  = 8;
  localparam int unsigned MODE_W   = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] RXERR_CNT_OFF = 5'h15;
  localparam logic [ADDR_W-1:0] EVT_OFF       = 5'h1b;
  localparam logic [ADDR_W-1:0] XCVR_OFF      = 5'h1f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned ENA_LSB        = 8;
  localparam int unsigned FLAG_LSB       = 0;
  localparam int unsigned XOVER_DIS_BIT  = 13;
  localparam int unsigned ENERGY_BIT     = 12;
  localparam int unsigned FORCE_LINK_BIT = 11;
  localparam int unsigned PWR_SAVE_BIT   = 10;
  localparam int unsigned IRQ_POL_BIT    = 9;
  localparam int unsigned JAB_EN_BIT     = 8;
  localparam int unsigned AN_DONE_BIT    = 7;
  localparam int unsigned FLOW_BIT       = 6;
  localparam int unsigned ISO_BIT        = 5;
  localparam int unsigned MODE_LSB       = 2;
  localparam int unsigned SQE_BIT        = 1;
  localparam int unsigned SCR_BIT        = 0;

  // Event order, shared by enables and flags
  localparam int unsigned EVT_JABBER     = 7;
  localparam int unsigned EVT_RX_ERR     = 6;
  localparam int unsigned EVT_PAGE_RX    = 5;
  localparam int unsigned EVT_PD_FAULT   = 4;
  localparam int unsigned EVT_LP_ACK     = 3;
  localparam int unsigned EVT_LINK_DOWN  = 2;
  localparam int unsigned EVT_REM_FAULT  = 1;
  localparam int unsigned EVT_LINK_UP    = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [DATA_W-1:0]  RXERR_CNT_RST  = 16'h0000;
  localparam logic [NUM_EVT-1:0] EVT_ENA_RST    = 8'h00;
  localparam logic [NUM_EVT-1:0] EVT_FLAG_RST   = 8'h00;
  localparam logic               XOVER_DIS_RST  = 1'h0;
  localparam logic               FORCE_LINK_RST = 1'h0;
  localparam logic               PWR_SAVE_RST   = 1'h1;
  localparam logic               IRQ_POL_RST    = 1'h0;
  localparam logic               JAB_EN_RST     = 1'h1;
  localparam logic               SQE_RST        = 1'h0;
  localparam logic               SCR_RST        = 1'h0;
  localparam logic               STATUS_RST     = 1'h0;
  localparam logic               IRQ_PIN_RST    = 1'h1;
  localparam logic [DATA_W-1:0]  RDATA_RST      = 16'h0000;

  // ****************************************************************
  // Operating mode codes
  // ****************************************************************
  localparam logic [MODE_W-1:0] MODE_NEGOTIATING = 3'h0;
  localparam logic [MODE_W-1:0] MODE_10_HALF     = 3'h1;
  localparam logic [MODE_W-1:0] MODE_100_HALF    = 3'h2;
  localparam logic [MODE_W-1:0] MODE_RESERVED    = 3'h3;
  localparam logic [MODE_W-1:0] MODE_10_FULL     = 3'h5;
  localparam logic [MODE_W-1:0] MODE_100_FULL    = 3'h6;
  localparam logic [MODE_W-1:0] MODE_ISOLATED    = 3'h7;

endpackage

// ### rtl/rx_error_counter.sv
// Counts packets that carried a receive error indication.
// Assumes receive valid and error inputs synchronous to clk_i.
`timescale 1ns/1ps
module rx_error_counter #(
  parameter int unsigned CNT_W = phy_vendor_pkg::DATA_W
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             rx_dv_i,
  input  wire logic             rx_er_i,
  output logic      [CNT_W-1:0] count_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             seen;
  } cnt_state_s;

  cnt_state_s state_q;
  cnt_state_s state_d;

  // ****************************************************************
  // Counting
  // ****************************************************************
  // Saturates rather than wraps so a busy link never reads as clean
  always_comb begin
    state_d = state_q;
    if (!rx_dv_i) begin
      state_d.seen = 1'b0;
    end else if (rx_er_i && !state_q.seen) begin
      state_d.seen = 1'b1;
      if (state_q.cnt != {CNT_W{1'b1}}) begin
        state_d.cnt = CNT_W'(state_q.cnt + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q.cnt  <= CNT_W'(phy_vendor_pkg::RXERR_CNT_RST);
      state_q.seen <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count_o = state_q.cnt;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_CNT_ONCE_PER_PACKET: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (state_q.seen && rx_dv_i) |=> $stable(count_o))
    else $error("error counter moved twice in one packet");

  AST_CNT_FIRST_ERROR: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (rx_dv_i && rx_er_i && !state_q.seen && count_o != {CNT_W{1'b1}})
      |=> (count_o == CNT_W'($past(count_o) + 1'b1)))
    else $error("error counter missed a packet");

endmodule

// ### rtl/event_flag_bank.sv
// Sticky event flags, cleared by a read strobe; a new event beats the clear.
// Assumes one-cycle or level event inputs synchronous to clk_i.
`timescale 1ns/1ps
module event_flag_bank #(
  parameter int unsigned NUM = phy_vendor_pkg::NUM_EVT
) (
  input  wire logic           clk_i,
  input  wire logic           nrst_i,
  input  wire logic [NUM-1:0] set_i,
  input  wire logic           clr_i,
  output logic      [NUM-1:0] flags_o
);

  typedef struct packed {
    logic [NUM-1:0] flags;
  } flag_state_s;

  flag_state_s    state_q;
  flag_state_s    state_d;
  logic [NUM-1:0] flag_nxt;

  // ****************************************************************
  // Per-flag update
  // ****************************************************************
  for (genvar g = 0; g < NUM; g++) begin : g_flag
    assign flag_nxt[g] = set_i[g] | (state_q.flags[g] & ~clr_i);
  end

  always_comb begin
    state_d       = state_q;
    state_d.flags = flag_nxt;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q.flags <= NUM'(phy_vendor_pkg::EVT_FLAG_RST);
    end else begin
      state_q <= state_d;
    end
  end

  assign flags_o = state_q.flags;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_FLAG_SET_WINS: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (set_i != '0) |=> ((flags_o & $past(set_i)) == $past(set_i)))
    else $error("event lost against a clear");

  AST_FLAG_CLEAR: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (clr_i && set_i == '0) |=> (flags_o == '0))
    else $error("flag survived the clearing read");

endmodule

// ### rtl/phy_vendor_regs.sv
// Vendor management registers: receive error count, event block, control.
// Assumes the management front end issues one-cycle read/write strobes.
`timescale 1ns/1ps
module phy_vendor_regs #(
  parameter int unsigned NUM_EVT = phy_vendor_pkg::NUM_EVT
) (
  input  wire logic                                clk_i,
  input  wire logic                                nrst_i,
  input  wire logic [phy_vendor_pkg::ADDR_W-1:0]   mgmt_addr_i,
  input  wire logic                                mgmt_wr_i,
  input  wire logic [phy_vendor_pkg::DATA_W-1:0]   mgmt_wdata_i,
  input  wire logic                                mgmt_rd_i,
  output logic      [phy_vendor_pkg::DATA_W-1:0]   mgmt_rdata_o,
  input  wire logic                                rx_dv_i,
  input  wire logic                                rx_er_i,
  input  wire logic [NUM_EVT-1:0]                  event_i,
  input  wire logic                                energy_detect_i,
  input  wire logic                                an_complete_i,
  input  wire logic                                flow_ctrl_ok_i,
  input  wire logic                                isolated_flag_i,
  input  wire logic [phy_vendor_pkg::MODE_W-1:0]   op_mode_i,
  output logic                                     crossover_disable_o,
  output logic                                     force_link_o,
  output logic                                     power_save_o,
  output logic                                     jabber_count_en_o,
  output logic                                     sqe_test_enable_o,
  output logic                                     scrambler_bypass_o,
  output logic                                     irq_pin_o
);

  localparam int unsigned DW = phy_vendor_pkg::DATA_W;
  localparam int unsigned MW = phy_vendor_pkg::MODE_W;

  typedef struct packed {
    logic [DW-1:0]      rdata;
    logic [NUM_EVT-1:0] ena;
    logic               xover_dis;
    logic               force_link;
    logic               pwr_save;
    logic               irq_pol;
    logic               jab_en;
    logic               sqe_en;
    logic               scr_bypass;
    logic               energy;
    logic               an_done;
    logic               flow_ok;
    logic               isolated;
    logic [MW-1:0]      mode;
    logic               irq_pin;
  } regs_s;

  regs_s              regs_q;
  regs_s              regs_d;
  logic [DW-1:0]      err_count;
  logic [NUM_EVT-1:0] flags;
  logic               flag_clr;
  logic               irq_active;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic addr_hit(
    input logic [phy_vendor_pkg::ADDR_W-1:0] addr,
    input logic [phy_vendor_pkg::ADDR_W-1:0] off
  );
    addr_hit = (addr == off);
  endfunction

  // Unlisted codes would mislead software, so they read as negotiating
  function automatic logic [MW-1:0] mode_code(
    input logic          iso,
    input logic [MW-1:0] raw
  );
    if (iso) begin
      mode_code = phy_vendor_pkg::MODE_ISOLATED;
    end else begin
      unique case (raw)
        phy_vendor_pkg::MODE_10_HALF,
        phy_vendor_pkg::MODE_100_HALF,
        phy_vendor_pkg::MODE_10_FULL,
        phy_vendor_pkg::MODE_100_FULL,
        phy_vendor_pkg::MODE_ISOLATED: mode_code = raw;
        default:                       mode_code = phy_vendor_pkg::MODE_NEGOTIATING;
      endcase
    end
  endfunction

  function automatic logic [DW-1:0] xcvr_word(input regs_s r);
    xcvr_word                                        = '0;
    xcvr_word[phy_vendor_pkg::XOVER_DIS_BIT]         = r.xover_dis;
    xcvr_word[phy_vendor_pkg::ENERGY_BIT]            = r.energy;
    xcvr_word[phy_vendor_pkg::FORCE_LINK_BIT]        = r.force_link;
    xcvr_word[phy_vendor_pkg::PWR_SAVE_BIT]          = r.pwr_save;
    xcvr_word[phy_vendor_pkg::IRQ_POL_BIT]           = r.irq_pol;
    xcvr_word[phy_vendor_pkg::JAB_EN_BIT]            = r.jab_en;
    xcvr_word[phy_vendor_pkg::AN_DONE_BIT]           = r.an_done;
    xcvr_word[phy_vendor_pkg::FLOW_BIT]              = r.flow_ok;
    xcvr_word[phy_vendor_pkg::ISO_BIT]               = r.isolated;
    xcvr_word[phy_vendor_pkg::MODE_LSB +: MW]        = r.mode;
    xcvr_word[phy_vendor_pkg::SQE_BIT]               = r.sqe_en;
    xcvr_word[phy_vendor_pkg::SCR_BIT]               = r.scr_bypass;
  endfunction

  // ****************************************************************
  // Leaves
  // ****************************************************************
  rx_error_counter #(
    .CNT_W   (DW)
  ) u_rx_error_counter (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .rx_dv_i (rx_dv_i),
    .rx_er_i (rx_er_i),
    .count_o (err_count)
  );

  assign flag_clr = mgmt_rd_i && addr_hit(mgmt_addr_i, phy_vendor_pkg::EVT_OFF);

  event_flag_bank #(
    .NUM     (NUM_EVT)
  ) u_event_flag_bank (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .set_i   (event_i),
    .clr_i   (flag_clr),
    .flags_o (flags)
  );

  assign irq_active = |(flags & regs_q.ena);

  // ****************************************************************
  // Register next state
  // ****************************************************************
  always_comb begin
    regs_d = regs_q;

    // Status sampled every cycle so reads show the live state
    regs_d.energy   = energy_detect_i;
    regs_d.an_done  = an_complete_i;
    regs_d.flow_ok  = flow_ctrl_ok_i;
    regs_d.isolated = isolated_flag_i;
    regs_d.mode     = mode_code(isolated_flag_i, op_mode_i);

    // Flags are not in this struct, so a write cannot touch them
    if (mgmt_wr_i && addr_hit(mgmt_addr_i, phy_vendor_pkg::EVT_OFF)) begin
      regs_d.ena = mgmt_wdata_i[phy_vendor_pkg::ENA_LSB +: NUM_EVT];
    end

    if (mgmt_wr_i && addr_hit(mgmt_addr_i, phy_vendor_pkg::XCVR_OFF)) begin
      regs_d.xover_dis  = mgmt_wdata_i[phy_vendor_pkg::XOVER_DIS_BIT];
      regs_d.force_link = mgmt_wdata_i[phy_vendor_pkg::FORCE_LINK_BIT];
      regs_d.pwr_save   = mgmt_wdata_i[phy_vendor_pkg::PWR_SAVE_BIT];
      regs_d.irq_pol    = mgmt_wdata_i[phy_vendor_pkg::IRQ_POL_BIT];
      regs_d.jab_en     = mgmt_wdata_i[phy_vendor_pkg::JAB_EN_BIT];
      regs_d.sqe_en     = mgmt_wdata_i[phy_vendor_pkg::SQE_BIT];
      regs_d.scr_bypass = mgmt_wdata_i[phy_vendor_pkg::SCR_BIT];
    end

    if (mgmt_rd_i) begin
      if (addr_hit(mgmt_addr_i, phy_vendor_pkg::RXERR_CNT_OFF)) begin
        regs_d.rdata = err_count;
      end else if (addr_hit(mgmt_addr_i, phy_vendor_pkg::EVT_OFF)) begin
        regs_d.rdata = {regs_q.ena, flags};
      end else if (addr_hit(mgmt_addr_i, phy_vendor_pkg::XCVR_OFF)) begin
        regs_d.rdata = xcvr_word(regs_q);
      end else begin
        regs_d.rdata = '0;
      end
    end

    // Pin lags the flags by one cycle; keeps the output a plain flop
    regs_d.irq_pin = irq_active ? regs_q.irq_pol : ~regs_q.irq_pol;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      regs_q.rdata      <= phy_vendor_pkg::RDATA_RST;
      regs_q.ena        <= phy_vendor_pkg::EVT_ENA_RST;
      regs_q.xover_dis  <= phy_vendor_pkg::XOVER_DIS_RST;
      regs_q.force_link <= phy_vendor_pkg::FORCE_LINK_RST;
      regs_q.pwr_save   <= phy_vendor_pkg::PWR_SAVE_RST;
      regs_q.irq_pol    <= phy_vendor_pkg::IRQ_POL_RST;
      regs_q.jab_en     <= phy_vendor_pkg::JAB_EN_RST;
      regs_q.sqe_en     <= phy_vendor_pkg::SQE_RST;
      regs_q.scr_bypass <= phy_vendor_pkg::SCR_RST;
      regs_q.energy     <= phy_vendor_pkg::STATUS_RST;
      regs_q.an_done    <= phy_vendor_pkg::STATUS_RST;
      regs_q.flow_ok    <= phy_vendor_pkg::STATUS_RST;
      regs_q.isolated   <= phy_vendor_pkg::STATUS_RST;
      regs_q.mode       <= phy_vendor_pkg::MODE_NEGOTIATING;
      regs_q.irq_pin    <= phy_vendor_pkg::IRQ_PIN_RST;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign mgmt_rdata_o        = regs_q.rdata;
  assign crossover_disable_o = regs_q.xover_dis;
  assign force_link_o        = regs_q.force_link;
  assign power_save_o        = regs_q.pwr_save;
  assign jabber_count_en_o   = regs_q.jab_en;
  assign sqe_test_enable_o   = regs_q.sqe_en;
  assign scrambler_bypass_o  = regs_q.scr_bypass;
  assign irq_pin_o           = regs_q.irq_pin;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_ENA_WRITE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::EVT_OFF) ##1 mgmt_rd_i
      && mgmt_addr_i == phy_vendor_pkg::EVT_OFF
      |=> (mgmt_rdata_o[15:8] == $past(mgmt_wdata_i[15:8], 2)))
    else $error("written enables not read back");

  AST_FLAGS_WRITE_IGNORED: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && !mgmt_rd_i && event_i == '0)
      |=> (flags == $past(flags)))
    else $error("write changed event flags");

  AST_IRQ_ASSERT: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ((flags & regs_q.ena) != '0) |=> (irq_pin_o == $past(regs_q.irq_pol)))
    else $error("pin idle with an enabled flag set");

  AST_IRQ_IDLE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ((flags & regs_q.ena) == '0) |=> (irq_pin_o != $past(regs_q.irq_pol)))
    else $error("pin active with no enabled flag");

  AST_READ_CLEARS: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (flag_clr && event_i == '0) ##1 (mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::EVT_OFF
      && event_i == '0) |=> (mgmt_rdata_o[7:0] == 8'h00))
    else $error("flags survived a read");

  AST_XCVR_CTRL: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> (power_save_o == $past(mgmt_wdata_i[10]))
        && (scrambler_bypass_o == $past(mgmt_wdata_i[0]))
        && (crossover_disable_o == $past(mgmt_wdata_i[13])))
    else $error("control bit did not take the write");

  AST_MODE_ISO: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    isolated_flag_i ##1 (mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> (mgmt_rdata_o[4:2] == 3'h7) && mgmt_rdata_o[5])
    else $error("isolated state not reported");

  AST_MODE_NOT_RESERVED: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    regs_q.mode != phy_vendor_pkg::MODE_RESERVED)
    else $error("reserved operating mode reported");

  AST_STATUS_FOLLOW: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ##1 (regs_q.energy == $past(energy_detect_i)) && (regs_q.an_done == $past(an_complete_i)))
    else $error("status bit not tracking its source");

  AST_FORCE_LINK_WRITE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> (force_link_o == $past(mgmt_wdata_i[phy_vendor_pkg::FORCE_LINK_BIT])))
    else $error("forced link bit did not take the write");

  AST_JABBER_EN_WRITE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> (jabber_count_en_o == $past(mgmt_wdata_i[phy_vendor_pkg::JAB_EN_BIT])))
    else $error("jabber enable did not take the write");

  AST_SQE_WRITE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> (sqe_test_enable_o == $past(mgmt_wdata_i[phy_vendor_pkg::SQE_BIT])))
    else $error("test enable did not take the write");

  AST_CTRL_HOLD: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !(mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF)
      |=> $stable(crossover_disable_o) && $stable(scrambler_bypass_o)
        && $stable(power_save_o) && $stable(force_link_o))
    else $error("control bit moved without a write");

  AST_COUNT_READ: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::RXERR_CNT_OFF)
      |=> (mgmt_rdata_o == $past(err_count)))
    else $error("counter read returned a stale value");

  AST_FLAG_READ: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::EVT_OFF)
      |=> (mgmt_rdata_o[phy_vendor_pkg::FLAG_LSB +: NUM_EVT] == $past(flags)))
    else $error("flag read lost a pending event");

  AST_RDATA_HOLD: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    !mgmt_rd_i |=> $stable(mgmt_rdata_o))
    else $error("read data moved without a read");

  AST_FLOW_FOLLOW: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> (regs_q.flow_ok == $past(flow_ctrl_ok_i)))
    else $error("flow control bit not tracking its source");

  AST_ISO_MODE: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    isolated_flag_i
      |=> regs_q.isolated && (regs_q.mode == phy_vendor_pkg::MODE_ISOLATED))
    else $error("isolated state not captured");

  AST_AN_DONE_RO: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (mgmt_wr_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF && !an_complete_i)
      |=> !regs_q.an_done)
    else $error("write set the negotiation complete bit");

  CVR_MODE_ISOLATED: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    isolated_flag_i && mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::XCVR_OFF);

  CVR_IRQ_RAISED: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    $changed(irq_pin_o) ##[1:20] flag_clr);

  CVR_EVENT_ON_CLEAR: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    flag_clr && event_i != '0);

  CVR_COUNT_READ: cover property (
    @(posedge clk_i) disable iff (!nrst_i)
    mgmt_rd_i && mgmt_addr_i == phy_vendor_pkg::RXERR_CNT_OFF && err_count != '0);

endmodule

// ### verif/mgmt_station.sv
// Station management model: strobed register reads and writes.
// Assumes the register block samples strobes on the rising edge.
`timescale 1ns/1ps
module mgmt_station (
  input  wire logic        clk_i,
  output logic      [4:0]  addr_o,
  output logic             wr_o,
  output logic      [15:0] wdata_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  // ************************************************
  // Access tasks
  // ************************************************
  initial begin
    addr_o = 5'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end
  // Stale write data inverted so a late sample shows up
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~v;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    v = rdata_i;
  endtask
  // Back-to-back pair: a write or a read, then a read of the same address
  task automatic pair(input logic [4:0] a, input logic w, input logic [15:0] v,
                      output logic [15:0] r1, output logic [15:0] r2);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = v;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~v;
    rd_o = 1'b1;
    r1 = rdata_i;
    @(negedge clk_i);
    rd_o = 1'b0;
    r2 = rdata_i;
  endtask
endmodule

// ### verif/phy_vendor_regs_bench.sv
// Self-checking bench for the vendor management register block.
// Assumes the station model owns the register strobes.
`timescale 1ns/1ps
module phy_vendor_status_interrupt_regs_bench;
  // ************************************************
  // Signals
  // ************************************************
  logic        clk_i = 0, nrst_i = 0, wr, rd, irq;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, d, d2;
  logic        dv = 0, er = 0, edet = 0, an = 0, flow = 0, iso = 0;
  logic [7:0]  evt = 0;
  logic [2:0]  mode = 0;
  logic [5:0]  ctl;
  int          err_count = 0, num_checks = 0;
  always #12.5 clk_i = ~clk_i;
  phy_vendor_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .mgmt_addr_i(addr), .mgmt_wr_i(wr),
    .mgmt_wdata_i(wdata), .mgmt_rd_i(rd), .mgmt_rdata_o(rdata), .rx_dv_i(dv), .rx_er_i(er),
    .event_i(evt), .energy_detect_i(edet), .an_complete_i(an), .flow_ctrl_ok_i(flow),
    .isolated_flag_i(iso), .op_mode_i(mode), .crossover_disable_o(ctl[5]),
    .force_link_o(ctl[4]), .power_save_o(ctl[3]), .jabber_count_en_o(ctl[2]),
    .sqe_test_enable_o(ctl[1]), .scrambler_bypass_o(ctl[0]), .irq_pin_o(irq));
  mgmt_station u_mac (.clk_i(clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd),
    .rdata_i(rdata));
  // ************************************************
  // Checks and verdict
  // ************************************************
  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    test_done();
  end
  // ************************************************
  // Tests
  // ************************************************
  initial begin
    repeat (2) @(negedge clk_i);
    nrst_i = 1;
    chk16("ctl", 16'h000c, {10'h0, ctl});
    chk1("irq", 1'b1, irq);
    u_mac.rd(5'h15, d); chk16("cnt", 16'h0000, d);
    u_mac.rd(5'h1b, d); chk16("evt", 16'h0000, d);
    u_mac.rd(5'h1f, d); chk16("xcvr", 16'h0500, d);
    u_mac.wr(5'h02, 16'hffff);
    u_mac.rd(5'h02, d); chk16("unmapped", 16'h0000, d);
    $display("reset test done");
    edet = 1; an = 1; flow = 1;
    u_mac.wr(5'h1f, 16'hffff);
    chk16("ctl", 16'h003f, {10'h0, ctl});
    for (int m = 0; m < 8; m++) begin
      mode = m[2:0];
      u_mac.rd(5'h1f, d);
      chk16("xcvr", 16'h3fc3 | ((m == 3 || m == 4) ? 16'h0 : 16'(m) << 2), d);
    end
    iso = 1;
    u_mac.rd(5'h1f, d); chk16("xcvr", 16'h3fff, d);
    edet = 0; an = 0; flow = 0; iso = 0;
    u_mac.wr(5'h1f, 16'h0200);
    chk16("ctl", 16'h0000, {10'h0, ctl});
    $display("control test done");
    u_mac.wr(5'h1b, 16'hffff);
    u_mac.rd(5'h1b, d); chk16("evt", 16'hff00, d);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i); evt = 8'h01 << i;
      @(negedge clk_i); evt = 8'h00;
      @(negedge clk_i); chk1("irq", 1'b1, irq);
      u_mac.rd(5'h1b, d); chk16("evt", 16'hff00 | (16'h1 << i), d);
      @(negedge clk_i); chk1("irq", 1'b0, irq);
    end
    u_mac.wr(5'h1b, 16'h00ff);
    @(negedge clk_i); evt = 8'h80;
    @(negedge clk_i); evt = 8'h00;
    @(negedge clk_i); chk1("irq", 1'b0, irq);
    u_mac.rd(5'h1b, d); chk16("evt", 16'h0080, d);
    fork
      u_mac.rd(5'h1b, d);
      begin
        @(negedge clk_i); evt = 8'h40;
        @(negedge clk_i); evt = 8'h00;
      end
    join
    chk16("evt", 16'h0000, d);
    u_mac.pair(5'h1b, 1'b0, 16'h0000, d, d2);
    chk16("evt", 16'h0040, d);
    chk16("evt", 16'h0000, d2);
    u_mac.wr(5'h1f, 16'h0000);
    u_mac.pair(5'h1b, 1'b1, 16'h0100, d, d2);
    chk16("evt", 16'h0100, d2);
    @(negedge clk_i); evt = 8'h01;
    @(negedge clk_i); evt = 8'h00;
    @(negedge clk_i); chk1("irq", 1'b0, irq);
    u_mac.rd(5'h1b, d);
    @(negedge clk_i); chk1("irq", 1'b1, irq);
    $display("event test done");
    repeat (2) begin
      @(negedge clk_i); dv = 1; er = 1;
      repeat (3) @(negedge clk_i);
      er = 0;
      @(negedge clk_i); dv = 0;
    end
    er = 1;
    repeat (2) @(negedge clk_i);
    er = 0;
    u_mac.rd(5'h15, d); chk16("cnt", 16'h0002, d);
    u_mac.wr(5'h15, 16'h1234);
    u_mac.rd(5'h15, d); chk16("cnt", 16'h0002, d);
    $display("counter test done");
    test_done();
  end
endmodule
